//--- rtl/cfg_loader_pkg.sv
// shared constants, state codes and state records of the configuration loader
package cfg_loader_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int POR_MAX_MS = 200;
  // longest time: integer division rounds down
  localparam int POR_CYCLES_INT = POR_MAX_MS * (CLK_HZ / 1000);
  localparam int POR_W = 21;
  localparam logic [POR_W-1:0] POR_CYCLES = POR_CYCLES_INT[POR_W-1:0];
  localparam logic [POR_W-1:0] POR_ONE = 21'h000001;
  localparam logic [POR_W-1:0] POR_ZERO = 21'h000000;

  // link clock cycles allowed for the done line after the last bit
  localparam int DONE_WAIT_W = 5;
  localparam logic [DONE_WAIT_W-1:0] DONE_WAIT_CYCLES = 5'h10;
  localparam logic [DONE_WAIT_W-1:0] DONE_WAIT_ONE = 5'h01;
  localparam logic [DONE_WAIT_W-1:0] DONE_WAIT_ZERO = 5'h00;

  // system cycles the error level is held on the shared line
  localparam int ERR_W = 8;
  localparam logic [ERR_W-1:0] ERR_HOLD_CYCLES = 8'h10;
  localparam logic [ERR_W-1:0] ERR_ONE = 8'h01;
  localparam logic [ERR_W-1:0] ERR_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // bitstream addressing
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] BIT_COUNT_DEF = 16'h0400;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////////
  // controller states, one-hot
  typedef enum logic [7:0] {
    ST_POR     = 8'h01,
    ST_RELEASE = 8'h02,
    ST_SLAVE   = 8'h04,
    ST_SEND    = 8'h08,
    ST_WAIT    = 8'h10,
    ST_IDLE    = 8'h20,
    ST_ERROR   = 8'h40,
    ST_HALT    = 8'h80
  } ctrl_state_t;

  // system clock domain state
  typedef struct packed {
    ctrl_state_t state;
    logic [POR_W-1:0] por_cnt;
    logic [ERR_W-1:0] err_cnt;
    logic [ADDR_W-1:0] addr;
    logic sel_s1;
    logic sel_s2;
    logic line_s1;
    logic line_s2;
    logic line_prev;
    logic auto_s1;
    logic auto_s2;
    logic tmo_s1;
    logic tmo_s2;
    logic tmo_prev;
    logic last_tog;
    logic line_oe_n;
    logic clk_out;
    logic clk_oe_n;
    logic data_out;
    logic data_oe_n;
    logic cascade_low;
    logic master;
  } sys_state_t;

  // link clock domain state
  typedef struct packed {
    logic tog_s1;
    logic tog_s2;
    logic tog_prev;
    logic busy;
    logic [DONE_WAIT_W-1:0] cnt;
    logic tmo_tog;
  } link_state_t;

endpackage

//--- rtl/config_stream_por_error_ctrl.sv
// power-up hold, role selection, bit streaming and error detection of the loader
// Functional notes
// - hold off configuration after power-up for at most 200 ms.
// - pull the shared reset/error line low during the power-on hold.
// - release the open-drain line when the hold ends; pull-up raises it.
// - on release sample the select input: high means slave, low means master.
// - slave keeps data output high impedance and does not drive the clock.
// - done rising before the whole bitstream is sent signals an error.
// - wait 16 link clock cycles after the last bit for done, else error.
// - auto-restart option restarts after an error; otherwise no restart.
// - an external low on the shared line returns the device to reset state.
// - while the line is low, clear the address and float the data output.
// - after the line rises, low select streams; high select stays stopped.
// - after its data the master floats data, drives cascade low, keeps clocking.
// - once done is high after all data, idle with data high, clock low.
`timescale 1ns/1ns
`default_nettype none

module config_stream_por_error_ctrl #(
  parameter logic [cfg_loader_pkg::POR_W-1:0] POR_CYCLES = cfg_loader_pkg::POR_CYCLES,
  parameter logic [cfg_loader_pkg::ADDR_W-1:0] BIT_COUNT = cfg_loader_pkg::BIT_COUNT_DEF
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CONFIG_CLOCK,
  input wire logic I_FPGA_STATUS_LOW,
  input wire logic I_DEVICE_SELECT_LOW,
  input wire logic I_AUTO_RESTART,
  input wire logic I_BIT_DATA,
  output logic O_FPGA_STATUS_LOW,
  output logic O_FPGA_STATUS_LOW_OE_N,
  output logic O_CONFIG_CLOCK,
  output logic O_CONFIG_CLOCK_OE_N,
  output logic O_CONFIG_DATA,
  output logic O_CONFIG_DATA_OE_N,
  output logic O_CASCADE_OUT_LOW,
  output logic O_MASTER,
  output logic [cfg_loader_pkg::ADDR_W-1:0] O_BIT_ADDR
);

  ////////////////////////////////////////////////////////////////////////////////
  // state records
  cfg_loader_pkg::sys_state_t s;
  cfg_loader_pkg::sys_state_t next_s;
  cfg_loader_pkg::link_state_t l;
  cfg_loader_pkg::link_state_t next_l;

  logic line_fall;
  logic tmo_event;

  // last counts of the two hold counters, one below the terminal value
  localparam logic [cfg_loader_pkg::ERR_W-1:0] ERR_HOLD_LAST =
    cfg_loader_pkg::ERR_HOLD_CYCLES - cfg_loader_pkg::ERR_ONE;
  localparam logic [cfg_loader_pkg::DONE_WAIT_W-1:0] DONE_WAIT_LAST =
    cfg_loader_pkg::DONE_WAIT_CYCLES - cfg_loader_pkg::DONE_WAIT_ONE;

  // puts every pin except the shared line into its stopped, reset-state form
  function automatic cfg_loader_pkg::sys_state_t stop_pins(
    input cfg_loader_pkg::sys_state_t v
  );
    cfg_loader_pkg::sys_state_t r;
    r = v;
    r.addr = cfg_loader_pkg::ADDR_ZERO;
    r.data_out = 1'b0;
    r.data_oe_n = 1'b1;
    r.clk_out = 1'b0;
    r.clk_oe_n = 1'b1;
    r.cascade_low = 1'b1;
    r.master = 1'b0;
    return r;
  endfunction

  // error entry: stop the pins and pull the shared line low for the hold
  function automatic cfg_loader_pkg::sys_state_t enter_error(
    input cfg_loader_pkg::sys_state_t v
  );
    cfg_loader_pkg::sys_state_t r;
    r = stop_pins(v);
    r.line_oe_n = 1'b0;
    r.err_cnt = cfg_loader_pkg::ERR_ZERO;
    r.state = cfg_loader_pkg::ST_ERROR;
    return r;
  endfunction

  // reset reaction: a low seen from outside drops everything and re-samples the role
  function automatic cfg_loader_pkg::sys_state_t enter_release(
    input cfg_loader_pkg::sys_state_t v
  );
    cfg_loader_pkg::sys_state_t r;
    r = stop_pins(v);
    r.line_oe_n = 1'b1;
    r.state = cfg_loader_pkg::ST_RELEASE;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // system domain next state
  always_comb begin
    next_s = s;
    // synchronisers: first stage feeds only the second
    next_s.sel_s1 = I_DEVICE_SELECT_LOW;
    next_s.sel_s2 = s.sel_s1;
    next_s.line_s1 = I_FPGA_STATUS_LOW;
    next_s.line_s2 = s.line_s1;
    next_s.line_prev = s.line_s2;
    next_s.auto_s1 = I_AUTO_RESTART;
    next_s.auto_s2 = s.auto_s1;
    next_s.tmo_s1 = l.tmo_tog;
    next_s.tmo_s2 = s.tmo_s1;
    next_s.tmo_prev = s.tmo_s2;
    line_fall = s.line_prev & ~s.line_s2;
    tmo_event = s.tmo_s2 ^ s.tmo_prev;

    unique case (s.state)
      cfg_loader_pkg::ST_POR: begin
        next_s.line_oe_n = 1'b0;
        next_s = stop_pins(next_s);
        // counting to the parameter keeps the hold at or under the maximum
        if (s.por_cnt >= POR_CYCLES - cfg_loader_pkg::POR_ONE) begin
          next_s.line_oe_n = 1'b1;
          next_s.state = cfg_loader_pkg::ST_RELEASE;
        end else begin
          next_s.por_cnt = s.por_cnt + cfg_loader_pkg::POR_ONE;
        end
      end

      cfg_loader_pkg::ST_RELEASE: begin
        next_s = stop_pins(next_s);
        next_s.line_oe_n = 1'b1;
        // the role is taken only once the pulled-up line is seen high
        if (s.line_s2) begin
          if (s.sel_s2) begin
            next_s.state = cfg_loader_pkg::ST_SLAVE;
          end else begin
            next_s.master = 1'b1;
            next_s.data_out = I_BIT_DATA;
            next_s.data_oe_n = 1'b0;
            next_s.clk_oe_n = 1'b0;
            next_s.addr = cfg_loader_pkg::ADDR_ONE;
            next_s.state = cfg_loader_pkg::ST_SEND;
          end
        end
      end

      cfg_loader_pkg::ST_SLAVE: begin
        // clock pin is only received, data floats
        next_s.data_oe_n = 1'b1;
        next_s.clk_oe_n = 1'b1;
        // select changes are ignored until the line falls
        if (line_fall) begin
          next_s = stop_pins(next_s);
          next_s.state = cfg_loader_pkg::ST_RELEASE;
        end
      end

      cfg_loader_pkg::ST_SEND: begin
        next_s.clk_out = ~s.clk_out;
        // an outside low wins over everything, even an early done
        if (line_fall) begin
          next_s = enter_release(next_s);
        end else if (s.sel_s2) begin
          // done before the last bit means the target saw a broken stream
          next_s = enter_error(next_s);
        end else if (s.clk_out) begin
          // new bit on the falling edge, target samples on the rising one
          if (s.addr >= BIT_COUNT) begin
            next_s.data_oe_n = 1'b1;
            next_s.cascade_low = 1'b0;
            next_s.last_tog = ~s.last_tog;
            next_s.state = cfg_loader_pkg::ST_WAIT;
          end else begin
            next_s.data_out = I_BIT_DATA;
            next_s.addr = s.addr + cfg_loader_pkg::ADDR_ONE;
          end
        end
      end

      cfg_loader_pkg::ST_WAIT: begin
        // clock keeps running so cascaded slaves can still send
        next_s.clk_out = ~s.clk_out;
        if (line_fall) begin
          next_s = enter_release(next_s);
        end else if (s.sel_s2) begin
          next_s.clk_out = 1'b0;
          next_s.data_out = 1'b1;
          next_s.data_oe_n = 1'b0;
          next_s.state = cfg_loader_pkg::ST_IDLE;
        end else if (tmo_event) begin
          // select still low after the grace count: the target did not start
          next_s = enter_error(next_s);
        end
      end

      cfg_loader_pkg::ST_IDLE: begin
        // low-power idle: pins parked until the line is pulled low again
        next_s.clk_out = 1'b0;
        next_s.data_out = 1'b1;
        if (line_fall) begin
          next_s = stop_pins(next_s);
          next_s.state = cfg_loader_pkg::ST_RELEASE;
        end
      end

      cfg_loader_pkg::ST_ERROR: begin
        next_s = stop_pins(next_s);
        next_s.line_oe_n = 1'b0;
        // the hold is long enough for the target's synchroniser to see the low
        if (s.err_cnt >= ERR_HOLD_LAST) begin
          next_s.line_oe_n = 1'b1;
          if (s.auto_s2) begin
            next_s.state = cfg_loader_pkg::ST_RELEASE;
          end else begin
            next_s.state = cfg_loader_pkg::ST_HALT;
          end
        end else begin
          next_s.err_cnt = s.err_cnt + cfg_loader_pkg::ERR_ONE;
        end
      end

      cfg_loader_pkg::ST_HALT: begin
        // stays stopped until someone else pulls the line low
        next_s = stop_pins(next_s);
        next_s.line_oe_n = 1'b1;
        if (line_fall) begin
          next_s.state = cfg_loader_pkg::ST_RELEASE;
        end
      end

      default: begin
        next_s = stop_pins(next_s);
        next_s.line_oe_n = 1'b0;
        next_s.por_cnt = cfg_loader_pkg::POR_ZERO;
        next_s.state = cfg_loader_pkg::ST_POR;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s <= '{
        state: cfg_loader_pkg::ST_POR,
        por_cnt: cfg_loader_pkg::POR_ZERO,
        err_cnt: cfg_loader_pkg::ERR_ZERO,
        addr: cfg_loader_pkg::ADDR_ZERO,
        line_oe_n: 1'b0,
        clk_oe_n: 1'b1,
        data_oe_n: 1'b1,
        cascade_low: 1'b1,
        default: 1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: counts the grace cycles on the clock seen at the pin
  // limitation: the count starts on the third link edge after the last bit
  // single toggles cross each way, so no multi-bit word can tear
  always_comb begin
    next_l = l;
    next_l.tog_s1 = s.last_tog;
    next_l.tog_s2 = l.tog_s1;
    next_l.tog_prev = l.tog_s2;
    if (l.tog_s2 ^ l.tog_prev) begin
      next_l.busy = 1'b1;
      next_l.cnt = cfg_loader_pkg::DONE_WAIT_ZERO;
    end else if (l.busy) begin
      if (l.cnt >= DONE_WAIT_LAST) begin
        next_l.busy = 1'b0;
        next_l.tmo_tog = ~l.tmo_tog;
      end else begin
        next_l.cnt = l.cnt + cfg_loader_pkg::DONE_WAIT_ONE;
      end
    end
  end

  always_ff @(posedge I_CONFIG_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      l <= '{cnt: cfg_loader_pkg::DONE_WAIT_ZERO, default: 1'b0};
    end else begin
      l <= next_l;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops, except the line value, which is tied low
  // open-drain line: the value is fixed low and only its enable moves
  assign O_FPGA_STATUS_LOW = 1'b0;
  assign O_FPGA_STATUS_LOW_OE_N = s.line_oe_n;
  assign O_CONFIG_CLOCK = s.clk_out;
  assign O_CONFIG_CLOCK_OE_N = s.clk_oe_n;
  assign O_CONFIG_DATA = s.data_out;
  assign O_CONFIG_DATA_OE_N = s.data_oe_n;
  assign O_CASCADE_OUT_LOW = s.cascade_low;
  assign O_MASTER = s.master;
  assign O_BIT_ADDR = s.addr;

endmodule

`default_nettype wire

//--- tb/fpga_cfg_model.sv
// behavioural fpga configuration port driving the done and status lines
`timescale 1ns/1ns
`default_nettype none
module fpga_cfg_model #(
  parameter int BITS = 8
) (
  input wire logic i_config_clock,
  input wire logic i_line,
  input wire logic [1:0] i_mode,
  output logic o_done,
  output logic o_status_low
);
  int n = 0;
  initial o_done = 1'b0;
  initial o_status_low = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // a low status line resets the port, as it does the memory
  always @(posedge i_config_clock or negedge i_line) begin
    if (!i_line) n <= 0;
    else n <= n + 1;
  end
  // mode 0 done after the whole stream, 1 early, 2 never, 3 crc fault
  always @(negedge i_config_clock or negedge i_line) begin
    if (!i_line) o_done <= 1'b0;
    else if ((i_mode == 2'h0 && n >= BITS) || (i_mode == 2'h1 && n >= 2)) o_done <= 1'b1;
  end
  always @(posedge i_config_clock) begin
    if (i_mode == 2'h3 && n == 3 && !o_status_low) begin
      o_status_low <= 1'b1;
      #1000 o_status_low <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/cfg_ctrl_sva.sv
// concurrent checks on the loader's pins
`timescale 1ns/1ns
`default_nettype none
module cfg_ctrl_sva #(
  parameter logic [cfg_loader_pkg::POR_W-1:0] POR_CYCLES = cfg_loader_pkg::POR_CYCLES
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  input wire logic I_FPGA_STATUS_LOW,
  input wire logic I_DEVICE_SELECT_LOW,
  input wire logic O_FPGA_STATUS_LOW_OE_N,
  input wire logic O_CONFIG_CLOCK,
  input wire logic O_CONFIG_CLOCK_OE_N,
  input wire logic O_CONFIG_DATA,
  input wire logic O_CONFIG_DATA_OE_N,
  input wire logic O_CASCADE_OUT_LOW,
  input wire logic O_MASTER,
  input wire logic [cfg_loader_pkg::ADDR_W-1:0] O_BIT_ADDR
);
  int pc;
  logic pd;
  int wc;
  // wc counts the wait for done after the own last bit
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pc <= 0;
      pd <= 1'b0;
      wc <= 0;
    end else begin
      if (pc < int'(POR_CYCLES) + 4) pc <= pc + 1;
      if (O_FPGA_STATUS_LOW_OE_N) pd <= 1'b1;
      wc <= (!O_CASCADE_OUT_LOW && !I_DEVICE_SELECT_LOW) ? wc + 1 : 0;
    end
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  ////////////////////////////////////////////////////////////////////////////////
  property p_por_end; pc == int'(POR_CYCLES) + 3 |-> pd; endproperty
  a_por_end: assert property (p_por_end) else $error("hold too long");
  property p_por_low; pc + 3 < int'(POR_CYCLES) |-> !O_FPGA_STATUS_LOW_OE_N; endproperty
  a_por_low: assert property (p_por_low) else $error("line released early");
  property p_slave; (!O_MASTER)[*2] |-> O_CONFIG_CLOCK_OE_N && O_CONFIG_DATA_OE_N; endproperty
  a_slave: assert property (p_slave) else $error("slave drives pins");
  property p_early; $rose(I_DEVICE_SELECT_LOW) && O_MASTER && O_CASCADE_OUT_LOW &&
    !O_CONFIG_DATA_OE_N |-> ##[1:6] !O_FPGA_STATUS_LOW_OE_N; endproperty
  a_early: assert property (p_early) else $error("early done missed");
  property p_wait_min; wc inside {[1:30]} |-> O_FPGA_STATUS_LOW_OE_N; endproperty
  a_wait_min: assert property (p_wait_min) else $error("timeout too soon");
  property p_wait_err; wc == 30 |-> ##[1:16] !O_FPGA_STATUS_LOW_OE_N; endproperty
  a_wait_err: assert property (p_wait_err) else $error("timeout missed");
  property p_ext; $fell(I_FPGA_STATUS_LOW) && O_FPGA_STATUS_LOW_OE_N |-> ##[1:5] !O_MASTER;
  endproperty
  a_ext: assert property (p_ext) else $error("no reset on low line");
  property p_clear; (!I_FPGA_STATUS_LOW)[*6] |->
    O_BIT_ADDR == cfg_loader_pkg::ADDR_ZERO && O_CONFIG_DATA_OE_N; endproperty
  a_clear: assert property (p_clear) else $error("not cleared");
  property p_step; $changed(O_BIT_ADDR) && O_BIT_ADDR != cfg_loader_pkg::ADDR_ZERO |->
    O_BIT_ADDR == $past(O_BIT_ADDR) + 1; endproperty
  a_step: assert property (p_step) else $error("address skipped");
  property p_idle; (!O_CASCADE_OUT_LOW && I_DEVICE_SELECT_LOW && I_FPGA_STATUS_LOW)[*6] |->
    O_CONFIG_DATA && !O_CONFIG_DATA_OE_N && !O_CONFIG_CLOCK && !O_CONFIG_CLOCK_OE_N; endproperty
  a_idle: assert property (p_idle) else $error("idle pins wrong");
  c_idle: cover property (!O_CASCADE_OUT_LOW && I_DEVICE_SELECT_LOW);
  c_err: cover property ($fell(O_FPGA_STATUS_LOW_OE_N));
  c_slave: cover property ($rose(I_FPGA_STATUS_LOW) ##4 !O_MASTER);
endmodule
bind config_stream_por_error_ctrl cfg_ctrl_sva #(.POR_CYCLES(POR_CYCLES)) cfg_ctrl_sva_i (.*);
`default_nettype wire

//--- tb/config_stream_por_error_ctrl_tb.sv
// self-checking bench of the loader facing an fpga port model
`timescale 1ns/1ns
`default_nettype none
module config_stream_por_error_ctrl_tb;
  localparam int NB = 8;
  localparam int PC = 20;
  logic I_SYS_CLK = 1'b0;
  logic I_RESET_N = 1'b0;
  logic I_AUTO_RESTART = 1'b0;
  logic I_BIT_DATA = 1'b0;
  logic O_FPGA_STATUS_LOW, O_FPGA_STATUS_LOW_OE_N, O_CONFIG_CLOCK, O_CONFIG_CLOCK_OE_N;
  logic O_CONFIG_DATA, O_CONFIG_DATA_OE_N, O_CASCADE_OUT_LOW, O_MASTER;
  logic [15:0] O_BIT_ADDR;
  logic lclk = 1'b0;
  logic lrun = 1'b0;
  logic sel_hi = 1'b0;
  logic tg = 1'b0;
  logic sb_on = 1'b0;
  logic done, crc;
  logic [1:0] mode = 2'h0;
  logic [NB-1:0] mem = '0;
  logic exq[$];
  int n_mismatch = 0;
  int check_count = 0;
  wire I_FPGA_STATUS_LOW = (O_FPGA_STATUS_LOW_OE_N | O_FPGA_STATUS_LOW) & !crc;
  wire I_DEVICE_SELECT_LOW = done | sel_hi;
  // slave clock only runs in tests started with select high
  wire I_CONFIG_CLOCK = O_CONFIG_CLOCK_OE_N ? (lrun & lclk) : O_CONFIG_CLOCK;
  // a released data line toggles so a stale bit cannot pass
  wire dw = O_CONFIG_DATA_OE_N ? tg : O_CONFIG_DATA;
  config_stream_por_error_ctrl #(.POR_CYCLES(21'h000014), .BIT_COUNT(16'h0008))
    config_stream_por_error_ctrl_i (.*);
  fpga_cfg_model #(.BITS(NB)) fpga_cfg_model_i (.i_config_clock(I_CONFIG_CLOCK),
    .i_line(I_FPGA_STATUS_LOW), .i_mode(mode), .o_done(done), .o_status_low(crc));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #50 I_SYS_CLK = ~I_SYS_CLK;
  initial forever #3 lclk = ~lclk;
  always @(posedge I_SYS_CLK) tg <= ~tg;
  always @(negedge I_SYS_CLK) I_BIT_DATA <= mem[O_BIT_ADDR[2:0]];
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // each streamed bit takes the oldest note off the queue
  always @(posedge I_CONFIG_CLOCK) begin
    if (sb_on && !O_CONFIG_CLOCK_OE_N && !O_CONFIG_DATA_OE_N && O_CASCADE_OUT_LOW) begin
      if (exq.size() == 0) chk(16'h0001, 16'h0000);
      else chk(16'(dw), 16'(exq.pop_front()));
    end
  end
  task summarize();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task w(input int k, input logic v, input int lim);
    logic s;
    for (int i = 0; i <= lim; i++) begin
      @(negedge I_SYS_CLK);
      s = (k == 0) ? I_FPGA_STATUS_LOW : (k == 1) ? I_DEVICE_SELECT_LOW : O_MASTER;
      if (s === v) return;
    end
    chk(16'h0001, 16'h0000);
    summarize();
  endtask
  task start(input logic [1:0] m, input logic a, input logic s);
    @(negedge I_SYS_CLK);
    I_RESET_N = 1'b0;
    mode = m;
    I_AUTO_RESTART = a;
    sel_hi = s;
    lrun = s;
    mem = NB'($urandom());
    repeat (4) @(negedge I_SYS_CLK);
    I_RESET_N = 1'b1;
    w(0, 1'b1, PC + 10);
  endtask
  initial begin
    void'($urandom(32'hedf8));
    start(2'h0, 1'b0, 1'b0);
    for (int i = 0; i < NB; i++) exq.push_back(mem[i]);
    sb_on = 1'b1;
    w(1, 1'b1, 80);
    repeat (6) @(negedge I_SYS_CLK);
    chk(16'(exq.size()), 16'h0000);
    chk({O_CONFIG_DATA, O_CONFIG_DATA_OE_N, O_CONFIG_CLOCK, O_CONFIG_CLOCK_OE_N}, 16'h0008);
    chk(16'(O_CASCADE_OUT_LOW), 16'h0000);
    sb_on = 1'b0;
    $display("test master stream finished");
    start(2'h1, 1'b0, 1'b0);
    w(0, 1'b0, 60);
    w(0, 1'b1, 40);
    repeat (20) @(negedge I_SYS_CLK);
    chk({O_MASTER, O_CONFIG_DATA_OE_N}, 16'h0001);
    $display("test early done finished");
    start(2'h2, 1'b1, 1'b0);
    w(0, 1'b0, 120);
    w(0, 1'b1, 40);
    w(2, 1'b1, 20);
    $display("test done timeout finished");
    start(2'h3, 1'b0, 1'b0);
    w(0, 1'b0, 60);
    repeat (6) @(negedge I_SYS_CLK);
    chk(O_BIT_ADDR, 16'h0000);
    chk({O_MASTER, O_CONFIG_DATA_OE_N}, 16'h0001);
    $display("test crc fault finished");
    start(2'h2, 1'b0, 1'b1);
    repeat (10) @(negedge I_SYS_CLK);
    chk({O_MASTER, O_CONFIG_CLOCK_OE_N, O_CONFIG_DATA_OE_N}, 16'h0003);
    sel_hi = 1'b0;
    repeat (10) @(negedge I_SYS_CLK);
    chk({O_MASTER, O_CONFIG_CLOCK_OE_N, O_CONFIG_DATA_OE_N}, 16'h0003);
    $display("test slave role finished");
    summarize();
  end
endmodule
`default_nettype wire
